// >>> hdl/psu_cmd_pkg.sv
// Constants and types shared by the supply command handler
package psu_cmd_pkg;
   // Clock and time base
   localparam int CLK_NS     = 8;
   localparam int MS_NS      = 1000000;
   localparam int CYC_PER_MS = (MS_NS + CLK_NS - 1) / CLK_NS;
   localparam int MIN_MS     = 60000;
   localparam int MIN_WRAP   = 60;
   // Argument limits
   localparam int DELAY_MAX  = 39000;
   localparam int START_MIN  = 80;
   localparam int START_MAX  = 240;
   localparam int STOP_MIN   = 75;
   localparam int STOP_MAX   = 150;
   localparam int THR_GAP    = 5;
   // Reset values
   localparam logic [7:0]  START_RST = 8'h5a;
   localparam logic [7:0]  STOP_RST  = 8'h50;
   localparam logic [15:0] DELAY_RST = 16'h0000;
   localparam logic [1:0]  SEL_RST   = 2'h0;
   // APB byte offsets
   localparam logic [7:0] A_CMD    = 8'h00;
   localparam logic [7:0] A_ARG    = 8'h04;
   localparam logic [7:0] A_REPLY  = 8'h08;
   localparam logic [7:0] A_STATUS = 8'h0c;
   localparam logic [7:0] A_THR    = 8'h10;
   // Leading command byte, then byte two selectors
   localparam logic [7:0] C_TON  = 8'h0f;
   localparam logic [7:0] C_TOFF = 8'h10;
   localparam logic [7:0] C_THR  = 8'h17;
   localparam logic [7:0] C_SLOT = 8'h1a;
   localparam logic [7:0] C_READ = 8'h1e;
   localparam logic [7:0] S_START = 8'h00;
   localparam logic [7:0] S_STOP  = 8'h01;
   localparam logic [7:0] S_IL    = 8'h1d;
   localparam logic [7:0] S_SEL   = 8'h1c;
   // Bytes two to four of read style commands
   localparam logic [23:0] K_RD_TON   = 24'h091d01;
   localparam logic [23:0] K_RD_TOFF  = 24'h091d02;
   localparam logic [23:0] K_RD_START = 24'h091c00;
   localparam logic [23:0] K_RD_STOP  = 24'h091c01;
   localparam logic [23:0] K_RD_IL    = 24'h091e1c;
   localparam logic [23:0] K_RD_CODE  = 24'h091e10;
   localparam logic [23:0] K_RD_LATCH = 24'h091e15;
   localparam logic [23:0] K_RD_SEL   = 24'h091f00;
   localparam logic [23:0] K_STORE    = 24'h090010;
   localparam logic [23:0] K_VIN      = 24'h080001;
   localparam logic [23:0] K_FREQ     = 24'h08001f;
   localparam logic [23:0] K_TEMP     = 24'h080e00;
   localparam logic [23:0] K_MIN      = 24'h081000;
   localparam logic [23:0] K_HR_LO    = 24'h081001;
   localparam logic [23:0] K_HR_HI    = 24'h081002;
   // Error and stop codes
   localparam logic [7:0] E_NONE  = 8'h00;
   localparam logic [7:0] E_RANGE = 8'h01;
   localparam logic [7:0] E_EMPTY = 8'h05;
   localparam logic [7:0] E_BAD   = 8'he0;
   localparam logic [7:0] SC_NONE = 8'h00;
   localparam logic [7:0] SC_REM  = 8'h02;
   localparam logic [7:0] SC_DROP = 8'h0a;
   localparam logic [7:0] SC_IL   = 8'hde;
   // Delay timer states
   typedef enum logic [1:0] {
      T_IDLE = 2'b00,
      T_ON   = 2'b01,
      T_OFF  = 2'b10
   } timer_state_t;
endpackage

// >>> hdl/slot_delay_timer.sv
// Millisecond delay timer for one output slot
`timescale 1ns/1ps
`default_nettype none
module slot_delay_timer
   import psu_cmd_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        tick,
   input  wire logic        start_on,
   input  wire logic        start_off,
   input  wire logic [15:0] delay,
   output logic             fire_on,
   output logic             fire_off
);
   timer_state_t state_q;  // Pending action
   logic [15:0]  left_q;   // Ticks still to wait

   // Newest request replaces a pending one; zero delay fires at once
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= T_IDLE;
         left_q  <= 16'h0000;
      end else if (start_on || start_off) begin
         state_q <= start_on ? T_ON : T_OFF;
         left_q  <= delay;
      end else if (state_q != T_IDLE) begin
         if (left_q == 16'h0000) begin
            state_q <= T_IDLE;
         end else if (tick) begin
            left_q <= left_q - 16'h0001;
         end
      end
   end

   // Fire once the count is spent
   always_comb begin
      fire_on  = (state_q == T_ON) && (left_q == 16'h0000);
      fire_off = (state_q == T_OFF) && (left_q == 16'h0000);
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   AST_TIMER_ZERO: assert property (
      start_on && delay == 16'h0000 && !start_off |=> fire_on ##1 !fire_on)
      else $error("zero delay did not fire once");
endmodule
`default_nettype wire

// >>> hdl/psu_seq_cmd.sv
// Sequence, monitor and status command handler behind APB
`timescale 1ns/1ps
`default_nettype none
module psu_seq_cmd
   import psu_cmd_pkg::*;
#(
   parameter int CYC_MS = CYC_PER_MS,
   parameter int MS_MIN = MIN_MS
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        input_ok,
   input  wire logic [2:0]  slot_present,
   input  wire logic [2:0]  on_req,
   input  wire logic [2:0]  off_req,
   input  wire logic [2:0]  fault_evt,
   input  wire logic [7:0]  fault_code,
   input  wire logic        latch_clear,
   input  wire logic [15:0] vin_rms,
   input  wire logic [15:0] vin_freq,
   input  wire logic [15:0] temp_c,
   output logic [2:0]       out_en,
   output logic [7:0]       start_thr_act,
   output logic [7:0]       stop_thr_act,
   output logic             nv_commit
);
   initial begin
      if (CYC_MS < 2 || CYC_MS > 131072 || MS_MIN < 2 || MS_MIN > 65535) begin
         $error("unsupported timing parameters");
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Declarations
   logic [15:0] ton_q [3];     // Turn-on delay per slot
   logic [15:0] toff_q [3];    // Turn-off delay per slot
   logic [3:0]  il_q [3];      // Interlock bitmap per slot
   logic [7:0]  code_q [3];    // Stop cause per slot
   logic [1:0]  sel_q;         // Selected slot, zero based
   logic [7:0]  start_q;       // Start threshold as set
   logic [7:0]  stop_q;        // Stop threshold as set
   logic [7:0]  start_nv_q;    // Start threshold as stored
   logic [7:0]  stop_nv_q;     // Stop threshold as stored
   logic [15:0] arg_q;         // Argument of next command
   logic [15:0] rep_q;         // Last reply value
   logic [7:0]  err_q;         // Last error code
   logic [2:0]  latched_q;     // Latch stopped slots
   logic [2:0]  en_q;          // Output enables
   logic [1:0]  in_sync_q;     // Input present synchroniser
   logic        in_q;          // Input present, delayed
   logic [16:0] div_q;         // Millisecond divider
   logic        tick;          // One cycle per millisecond
   logic [15:0] ms_q;          // Milliseconds in minute
   logic [5:0]  min_q;         // Minutes 0..59
   logic [31:0] hr_q;          // Hours
   logic        commit_q;      // Storage commit pulse
   logic        wr_cmd;        // Command write
   logic        wr_arg;        // Argument write
   logic [7:0]  b0;            // Frame byte 0
   logic [7:0]  b2;            // Frame byte 2
   logic [23:0] key;           // Frame bytes 2..4
   logic [15:0] rep_d;         // Reply value
   logic [7:0]  err_d;         // Error code
   logic        do_ton;        // Store turn-on delay
   logic        do_toff;       // Store turn-off delay
   logic        do_start;      // Store start threshold
   logic        do_stop;       // Store stop threshold
   logic        do_il;         // Store interlock bitmap
   logic        do_sel;        // Store selected slot
   logic        do_store;      // Save settings
   logic [2:0]  fire_on;       // Delayed turn on
   logic [2:0]  fire_off;      // Delayed turn off
   logic [2:0]  il_hit;        // Stop forced by other slot
   logic        all_latched;   // Every present slot latched
   logic        in_rise;       // Input came back
   logic        in_fall;       // Input went away
   logic [3:0]  present_map;   // Presence in bitmap form

   ////////////////////////////////////////////////////////////////////
   // APB slave, zero wait states
   assign pready = 1'b1;
   assign wr_cmd = psel && penable && pwrite && (paddr == A_CMD);
   assign wr_arg = psel && penable && pwrite && (paddr == A_ARG);
   assign b0  = pwdata[31:24];
   assign b2  = pwdata[23:16];
   assign key = pwdata[23:0];
   assign present_map = {slot_present, |slot_present};

   // Unmapped offsets answer with an error
   always_comb begin
      pslverr = 1'b0;
      if (psel && penable) begin
         pslverr = !(paddr inside {A_CMD, A_ARG, A_REPLY, A_STATUS, A_THR});
      end
   end

   // Read mux, all sources are flops
   always_comb begin
      prdata = 32'h0000_0000;
      case (paddr)
         A_ARG:    prdata = {16'h0000, arg_q};
         A_REPLY:  prdata = {8'h00, err_q, rep_q};
         A_STATUS: prdata = {20'h00000, 2'b00, sel_q, 1'b0, latched_q, 1'b0, en_q};
         A_THR:    prdata = {start_thr_act, stop_thr_act, start_q, stop_q};
         default:  prdata = 32'h0000_0000;
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // Command decode
   always_comb begin
      rep_d    = 16'h0000;
      err_d    = E_NONE;
      do_ton   = 1'b0;
      do_toff  = 1'b0;
      do_start = 1'b0;
      do_stop  = 1'b0;
      do_il    = 1'b0;
      do_sel   = 1'b0;
      do_store = 1'b0;
      case (b0)
         C_TON: begin
            if (arg_q > 16'(DELAY_MAX)) err_d = E_RANGE;
            else begin
               do_ton = 1'b1;
               rep_d  = arg_q;
            end
         end
         C_TOFF: begin
            if (arg_q > 16'(DELAY_MAX)) err_d = E_RANGE;
            else begin
               do_toff = 1'b1;
               rep_d   = arg_q;
            end
         end
         C_THR: begin
            rep_d = arg_q;
            if (b2 == S_START) begin
               if (arg_q < 16'(START_MIN) || arg_q > 16'(START_MAX) ||
                   arg_q <= {8'h00, stop_q} + 16'(THR_GAP)) err_d = E_RANGE;
               else do_start = 1'b1;
            end else if (b2 == S_STOP) begin
               if (arg_q < 16'(STOP_MIN) || arg_q > 16'(STOP_MAX) ||
                   arg_q + 16'(THR_GAP) >= {8'h00, start_q}) err_d = E_RANGE;
               else do_stop = 1'b1;
            end else err_d = E_BAD;
         end
         C_SLOT: begin
            rep_d = arg_q;
            if (b2 == S_IL) begin
               if (arg_q > 16'h000f) err_d = E_RANGE;
               else if ((arg_q[3:0] & present_map) == 4'h0) err_d = E_EMPTY;
               else do_il = 1'b1;
            end else if (b2 == S_SEL) begin
               if (arg_q < 16'h0001 || arg_q > 16'h0003) err_d = E_RANGE;
               else if (!slot_present[arg_q[1:0] - 2'd1]) err_d = E_EMPTY;
               else do_sel = 1'b1;
            end else err_d = E_BAD;
         end
         C_READ: begin
            case (key)
               K_RD_TON:   rep_d = ton_q[sel_q];
               K_RD_TOFF:  rep_d = toff_q[sel_q];
               K_RD_START: rep_d = {8'h00, start_q};
               K_RD_STOP:  rep_d = {8'h00, stop_q};
               K_RD_IL:    rep_d = {12'h000, il_q[sel_q]};
               K_RD_CODE:  rep_d = {8'h00, code_q[sel_q]};
               K_RD_LATCH: rep_d = {12'h000, latched_q, all_latched};
               K_RD_SEL:   rep_d = {14'h0000, sel_q + 2'd1};
               K_STORE:    do_store = 1'b1;
               K_VIN:      rep_d = vin_rms;
               K_FREQ:     rep_d = vin_freq;
               K_TEMP:     rep_d = temp_c;
               K_MIN:      rep_d = {10'h000, min_q};
               K_HR_LO:    rep_d = hr_q[15:0];
               K_HR_HI:    rep_d = hr_q[31:16];
               default:    err_d = E_BAD;
            endcase
         end
         default: err_d = E_BAD;
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // Argument and reply registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         arg_q <= 16'h0000;
         rep_q <= 16'h0000;
         err_q <= E_NONE;
      end else begin
         if (wr_arg) arg_q <= pwdata[15:0];
         if (wr_cmd) begin
            rep_q <= rep_d;
            err_q <= err_d;
         end
      end
   end

   // Settings; refused commands leave them untouched
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sel_q   <= SEL_RST;
         start_q <= START_RST;
         stop_q  <= STOP_RST;
         for (int i = 0; i < 3; i++) begin
            ton_q[i]  <= DELAY_RST;
            toff_q[i] <= DELAY_RST;
            il_q[i]   <= 4'h0;
         end
      end else if (wr_cmd) begin
         if (do_ton)   ton_q[sel_q]  <= arg_q;
         if (do_toff)  toff_q[sel_q] <= arg_q;
         if (do_il)    il_q[sel_q]   <= arg_q[3:0];
         if (do_sel)   sel_q         <= arg_q[1:0] - 2'd1;
         if (do_start) start_q       <= arg_q[7:0];
         if (do_stop)  stop_q        <= arg_q[7:0];
      end
   end

   // saved copy becomes active only when input returns
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         start_nv_q    <= START_RST;
         stop_nv_q     <= STOP_RST;
         start_thr_act <= START_RST;
         stop_thr_act  <= STOP_RST;
      end else begin
         if (wr_cmd && do_store) begin
            start_nv_q <= start_q;
            stop_nv_q  <= stop_q;
         end
         if (in_rise) begin
            start_thr_act <= start_nv_q;
            stop_thr_act  <= stop_nv_q;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Input presence, a pin, synchronised first
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         in_sync_q <= 2'b00;
         in_q      <= 1'b0;
      end else begin
         in_sync_q <= {in_sync_q[0], input_ok};
         in_q      <= in_sync_q[1];
      end
   end
   assign in_rise = in_sync_q[1] && !in_q;
   assign in_fall = !in_sync_q[1] && in_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) div_q <= 17'h00000;
      else if (tick) div_q <= 17'h00000;
      else div_q <= div_q + 17'h00001;
   end
   assign tick = (div_q == 17'(CYC_MS - 1));

   // minute and hour counters while input is present
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ms_q     <= 16'h0000;
         min_q    <= 6'h00;
         hr_q     <= 32'h0000_0000;
         commit_q <= 1'b0;
      end else begin
         commit_q <= 1'b0;
         if (in_sync_q[1] && tick) begin
            if (ms_q == 16'(MS_MIN - 1)) begin
               ms_q <= 16'h0000;
               commit_q <= 1'b1;
               if (min_q == 6'(MIN_WRAP - 1)) begin
                  min_q <= 6'h00;
                  hr_q <= hr_q + 32'h0000_0001;
               end else min_q <= min_q + 6'h01;
            end else ms_q <= ms_q + 16'h0001;
         end
         if (wr_cmd && do_store) commit_q <= 1'b1;
      end
   end
   assign nv_commit = commit_q;

   ////////////////////////////////////////////////////////////////////
   // Per slot timers and stop logic
   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : slot
         slot_delay_timer timer (
            .pclk      (pclk),
            .presetn   (presetn),
            .tick      (tick),
            .start_on  (on_req[g]),
            .start_off (off_req[g]),
            .delay     (on_req[g] ? ton_q[g] : toff_q[g]),
            .fire_on   (fire_on[g]),
            .fire_off  (fire_off[g])
         );
         // bit 0 stands for every slot
         always_comb begin
            il_hit[g] = 1'b0;
            for (int j = 0; j < 3; j++) begin
               if (j != g && fault_evt[j] && (il_q[j][g + 1] || il_q[j][0])) begin
                  il_hit[g] = 1'b1;
               end
            end
         end
         // Own fault beats interlock, then input drop, then timers
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               en_q[g]      <= 1'b0;
               latched_q[g] <= 1'b0;
               code_q[g]    <= SC_NONE;
            end else if (fault_evt[g]) begin
               en_q[g]      <= 1'b0;
               latched_q[g] <= 1'b1;
               code_q[g]    <= fault_code;
            end else if (il_hit[g]) begin
               en_q[g]      <= 1'b0;
               latched_q[g] <= 1'b1;
               code_q[g]    <= SC_IL;
            end else begin
               // Clear loses to a same-cycle latch above
               if (latch_clear) latched_q[g] <= 1'b0;
               if (in_fall) begin
                  en_q[g]   <= 1'b0;
                  code_q[g] <= SC_DROP;
               end else if (fire_off[g]) begin
                  en_q[g]   <= 1'b0;
                  code_q[g] <= SC_REM;
               end else if (fire_on[g] && !latched_q[g] && in_sync_q[1]) begin
                  en_q[g]   <= 1'b1;
                  code_q[g] <= SC_NONE;
               end
            end
         end
      end
   endgenerate
   assign out_en = en_q;
   assign all_latched = (|slot_present) && ((latched_q | ~slot_present) == 3'b111);

   ////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   AST_TON_ECHO: assert property (
      wr_cmd && b0 == C_TON && arg_q <= 16'(DELAY_MAX)
      |=> rep_q == $past(arg_q) && err_q == E_NONE ##1 ton_q[sel_q] == $past(arg_q, 2))
      else $error("turn-on delay not stored");
   AST_DELAY_RANGE: assert property (
      wr_cmd && b0 == C_TOFF && arg_q > 16'(DELAY_MAX) |=> err_q == E_RANGE)
      else $error("oversized delay accepted");
   AST_START_GAP: assert property (
      wr_cmd && b0 == C_THR && b2 == S_START && arg_q <= {8'h00, stop_q} + 16'(THR_GAP)
      |=> err_q == E_RANGE && $stable(start_q))
      else $error("start threshold gap not enforced");
   AST_STOP_GAP: assert property (
      wr_cmd && b0 == C_THR && b2 == S_STOP && arg_q + 16'(THR_GAP) >= {8'h00, start_q}
      |=> err_q == E_RANGE && $stable(stop_q))
      else $error("stop threshold gap not enforced");
   AST_IL_EMPTY: assert property (
      wr_cmd && b0 == C_SLOT && b2 == S_IL && arg_q < 16'h0010 &&
      (arg_q[3:0] & present_map) == 4'h0 |=> err_q == E_EMPTY)
      else $error("interlock to empty slot accepted");
   AST_MIN_WRAP: assert property (
      min_q < 6'(MIN_WRAP))
      else $error("minute counter out of range");
   AST_LATCH_ALL: assert property (
      wr_cmd && b0 == C_READ && key == K_RD_LATCH
      |=> rep_q[0] == $past(all_latched) && rep_q[3:1] == $past(latched_q))
      else $error("latched bitmap reply wrong");
   AST_FAULT_STOP: assert property (
      fault_evt[0] |=> !out_en[0] && latched_q[0] && code_q[0] == $past(fault_code))
      else $error("fault did not stop slot");
   AST_THR_LATE: assert property (
      !in_rise |=> $stable(start_thr_act) && $stable(stop_thr_act))
      else $error("threshold applied before restart");
endmodule
`default_nettype wire

// >>> test/host_apb.sv
// Host side model that issues APB transfers to the handler
`timescale 1ns/1ps
`default_nettype none
module host_apb (
   input  wire logic        pclk,
   input  wire logic        pready,
   input  wire logic [31:0] prdata,
   input  wire logic        pslverr,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [7:0]       paddr,
   output logic [31:0]      pwdata
);
   // Idle bus at time zero
   initial {psel, penable, pwrite, paddr, pwdata} = '0;
   // command bytes and argument travel as words
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Wait for ready; only the bench watchdog ends a dead wait
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Released data must not keep looking valid
      pwdata <= ~d;
   endtask
endmodule
`default_nettype wire

// >>> test/tb_psu_seq_cmd.sv
// Bench for the supply command handler
`timescale 1ns/1ps
`default_nettype none
module tb_psu_seq_cmd;
   import psu_cmd_pkg::*;
   logic        pclk = 0, presetn = 0, input_ok = 0, latch_clear = 0;
   logic        psel, penable, pwrite, pready, pslverr, nv_commit, e;
   logic [7:0]  paddr, start_thr_act, stop_thr_act, fault_code = 0;
   logic [31:0] pwdata, prdata, q;
   logic [2:0]  on_req = 0, off_req = 0, fault_evt = 0, out_en, slot_present = 3'h5;
   int          fail_count = 0, comparisons = 0, n, commits = 0;
   // Rows: command word, argument, error byte and reply value
   logic [71:0] rows [27] = '{
      72'h1e091d01_0000_000000,
      72'h0f000000_9858_009858,
      72'h0f000000_9859_010000,
      72'h1e091d01_0000_009858,
      72'h10000000_0384_000384,
      72'h1e091d02_0000_000384,
      72'h17000000_0064_000064,
      72'h17010000_005f_010000,
      72'h17010000_005a_00005a,
      72'h17000000_005f_010000,
      72'h17000000_00f1_010000,
      72'h17000000_0060_000060,
      72'h1e091c00_0000_000060,
      72'h1e091c01_0000_00005a,
      72'h1a1c0000_0002_050000,
      72'h1a1c0000_0003_000003,
      72'h1e091f00_0000_000003,
      72'h1e091d01_0000_000000,
      72'h1a1d0000_0004_050000,
      72'h1a1d0000_0002_000002,
      72'h1e091e1c_0000_000002,
      72'h1e080001_0000_005dca,
      72'h1e08001f_0000_0001e1,
      72'h1e080e00_0000_00ffe7,
      72'h1e081002_0000_000000,
      72'h10000000_a000_010000,
      72'h1e091f01_0000_e00000
   };
   always #4 pclk = ~pclk;
   // Short millisecond and minute so delays fit the run
   psu_seq_cmd #(.CYC_MS(4), .MS_MIN(3)) DUT (.pclk, .presetn, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .input_ok,
      .slot_present, .on_req, .off_req, .fault_evt, .fault_code,
      .latch_clear, .vin_rms(16'h5dca), .vin_freq(16'h01e1),
      .temp_c(16'hffe7), .out_en, .start_thr_act, .stop_thr_act, .nv_commit);
   host_apb u_host (.pclk, .pready, .prdata, .pslverr, .psel, .penable,
      .pwrite, .paddr, .pwdata);
   // Count storage commit pulses, sampled at each rising edge
   always @(posedge pclk) begin
      if (nv_commit === 1'b1) commits <= commits + 1;
   end
   // Compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   // Argument, command, then reply word
   task automatic cmd(input logic [31:0] c, input logic [15:0] a);
      u_host.xfer(1'b1, A_ARG, {16'h0, a}, q, e);
      u_host.xfer(1'b1, A_CMD, c, q, e);
      u_host.xfer(1'b0, A_REPLY, 32'h0, q, e);
   endtask
   task automatic wrap_up;
      $display("comparisons %0d fail_count %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // Watchdog well past the expected run
   initial begin
      #200000;
      fail_count++;
      wrap_up;
   end
   initial begin
      repeat (10) @(posedge pclk);
      chk({29'h0, out_en}, 32'h0);
      presetn <= 1'b1;
      input_ok <= 1'b1;
      repeat (8) @(posedge pclk);
      u_host.xfer(1'b0, A_THR, 32'h0, q, e);
      chk(q, 32'h5a505a50);
      u_host.xfer(1'b0, 8'h20, 32'h0, q, e);
      chk({31'h0, e}, 32'h1);
      $display("bus done");
      // Refused rows only carry an error byte worth checking
      foreach (rows[i]) begin
         cmd(rows[i][71:40], rows[i][39:24]);
         if (rows[i][23:16] !== 8'h00) chk({24'h0, q[23:16]}, {24'h0, rows[i][23:16]});
         else chk({8'h0, q[23:0]}, {8'h0, rows[i][23:0]});
      end
      $display("table done");
      // Slot one 5 ms turn-on, slot three immediate
      cmd(32'h1a1c0000, 16'h1);
      cmd(32'h0f000000, 16'h5);
      on_req <= 3'h5;
      @(posedge pclk);
      on_req <= 3'h0;
      for (n = 0; n < 60 && out_en[0] !== 1'b1; n++) @(posedge pclk);
      chk({31'h0, n >= 14 && n <= 26}, 32'h1);
      chk({29'h0, out_en}, 32'h5);
      // Slot three faults and drags slot one down
      fault_evt <= 3'h4;
      fault_code <= 8'h32;
      @(posedge pclk);
      fault_evt <= 3'h0;
      repeat (2) @(posedge pclk);
      chk({29'h0, out_en}, 32'h0);
      cmd(32'h1e091e15, 16'h0);
      chk({16'h0, q[15:0]}, 32'hb);
      // Slot two fitted but never latched: not all latched
      slot_present <= 3'h7;
      cmd(32'h1e091e15, 16'h0);
      chk({16'h0, q[15:0]}, 32'ha);
      slot_present <= 3'h5;
      cmd(32'h1e091e10, 16'h0);
      chk({16'h0, q[15:0]}, 32'hde);
      cmd(32'h1a1c0000, 16'h3);
      cmd(32'h1e091e10, 16'h0);
      chk({16'h0, q[15:0]}, 32'h32);
      // Clear latches, slot three on then off at once
      latch_clear <= 1'b1;
      @(posedge pclk);
      latch_clear <= 1'b0;
      on_req <= 3'h4;
      @(posedge pclk);
      on_req <= 3'h0;
      repeat (3) @(posedge pclk);
      chk({29'h0, out_en}, 32'h4);
      off_req <= 3'h4;
      @(posedge pclk);
      off_req <= 3'h0;
      repeat (3) @(posedge pclk);
      chk({29'h0, out_en}, 32'h0);
      cmd(32'h1e091e10, 16'h0);
      chk({16'h0, q[15:0]}, 32'h2);
      // Slot one faults on its own
      fault_evt <= 3'h1;
      fault_code <= 8'h65;
      @(posedge pclk);
      fault_evt <= 3'h0;
      cmd(32'h1a1c0000, 16'h1);
      cmd(32'h1e091e10, 16'h0);
      chk({16'h0, q[15:0]}, 32'h65);
      cmd(32'h1e081000, 16'h0);
      chk({31'h0, q[15:0] < 16'd60}, 32'h1);
      // Twelve cycles per short minute, ten in 120
      n = commits;
      repeat (120) @(posedge pclk);
      chk(commits - n, 32'd10);
      $display("sequence done");
      // Thresholds wait for store and an input restart
      u_host.xfer(1'b0, A_THR, 32'h0, q, e);
      chk(q, 32'h5a50605a);
      input_ok <= 1'b0;
      repeat (8) @(posedge pclk);
      n = commits;
      cmd(32'h1e090010, 16'h0);
      chk(commits - n, 32'd1);
      input_ok <= 1'b1;
      repeat (8) @(posedge pclk);
      u_host.xfer(1'b0, A_THR, 32'h0, q, e);
      chk(q, 32'h605a605a);
      cmd(32'h1e091e10, 16'h0);
      chk({16'h0, q[15:0]}, 32'h0a);
      $display("threshold done");
      // Mid-run reset puts settings back
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      chk({29'h0, out_en}, 32'h0);
      presetn <= 1'b1;
      repeat (8) @(posedge pclk);
      u_host.xfer(1'b0, A_THR, 32'h0, q, e);
      chk(q, 32'h5a505a50);
      cmd(32'h1e091d01, 16'h0);
      chk({8'h0, q[23:0]}, 32'h0);
      cmd(32'h1e091f00, 16'h0);
      chk({16'h0, q[15:0]}, 32'h1);
      $display("reset done");
      wrap_up;
   end
endmodule
`default_nettype wire
